// ==== design/ura_cfg.svh ====
/*
  Timing and encoding constants for the suspend, resume and attach sequencer.
  Assumes a 10 MHz controller clock; every cycle count is derived from its time.
*/
`ifndef URA_CFG_SVH
`define URA_CFG_SVH

// ----------------------------------------------------------------------------
// clock
// ----------------------------------------------------------------------------
`define URA_CLK_PERIOD_NS      100
`define URA_NS_PER_MS          1000000

// least times round up, longest times round down, never below one cycle
`define URA_CYC_UP(ns)         ((((ns) + `URA_CLK_PERIOD_NS - 1) / `URA_CLK_PERIOD_NS) < 1 ? 1 : \
                                (((ns) + `URA_CLK_PERIOD_NS - 1) / `URA_CLK_PERIOD_NS))
`define URA_CYC_DN(ns)         (((ns) / `URA_CLK_PERIOD_NS) < 1 ? 1 : ((ns) / `URA_CLK_PERIOD_NS))

// ----------------------------------------------------------------------------
// times
// ----------------------------------------------------------------------------
`define URA_T_WAKE_IDLE_MS     5
`define URA_T_WAKE_DRIVE_MS    10
`define URA_T_OSC_WAIT_MS      5
`define URA_T_RESUME_K_MS      2
`define URA_T_RESUME_K_MIN_MS  1
`define URA_T_RESUME_K_MAX_MS  15
`define URA_T_SUSP_IDLE_MS     3
`define URA_T_DEBOUNCE_MS      100
`define URA_T_FILT_NS          2500
`define URA_T_RESTORE_NS       1250

`define URA_FILT_CYC           `URA_CYC_UP(`URA_T_FILT_NS)
`define URA_RESTORE_CYC        `URA_CYC_DN(`URA_T_RESTORE_NS)

// ----------------------------------------------------------------------------
// line states and operating modes
// ----------------------------------------------------------------------------
`define URA_LS_SE0             2'h0
`define URA_LS_J               2'h1
`define URA_LS_K               2'h2
`define URA_OPM_NORMAL         2'h0
`define URA_OPM_NO_STUFF       2'h2
`define URA_TXDATA_ZERO        8'h00

`endif

// ==== design/ura_line_filter.sv ====
/*
  Line state qualifier: reports a state only after it has been held unbroken.
  Assumes line_in is already synchronised to clk.
*/
`timescale 1ns/1ps
`include "ura_cfg.svh"

module ura_line_filter #(
  parameter int FILT_CYC = `URA_FILT_CYC
) (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [1:0] line_in,
  output logic      [1:0] line_state,
  output logic            line_valid
);

  localparam logic [7:0] FILT_M1 = 8'(FILT_CYC - 1);

  logic [1:0] prev_reg;
  logic [7:0] cnt_reg;
  logic       valid_reg;

  // --------------------------------------------------------------------------
  // hold counter
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prev_reg <= `URA_LS_SE0;
      cnt_reg  <= 8'h00;
    end else begin
      prev_reg <= line_in;
      if (line_in != prev_reg) begin
        cnt_reg <= 8'h00;
      end else if (cnt_reg != FILT_M1) begin
        cnt_reg <= cnt_reg + 8'h01;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      valid_reg <= 1'b0;
    end else begin
      valid_reg <= (line_in == prev_reg) && (cnt_reg == FILT_M1);
    end
  end

  assign line_state = prev_reg;
  assign line_valid = valid_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_filter_hold: assert property ($rose(line_valid) |-> $past(cnt_reg) == FILT_M1)
    else $error("line state qualified before hold time");

endmodule

// ==== design/ura_pkg.sv ====
/*
  Types shared by the sequencer, the bench and the transceiver model.
  Assumes ura_cfg.svh supplies all numeric constants.
*/
package ura_pkg;

  // --------------------------------------------------------------------------
  // transceiver control bundle
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic       suspendn;
    logic [1:0] opmode;
    logic       termselect;
    logic       xcvrselect;
    logic       txvalid;
    logic [7:0] txdata;
  } ura_utmi_ctrl_s;

  typedef struct packed {
    logic attached;
    logic suspended;
    logic hs_mode;
    logic resuming;
  } ura_status_s;

  typedef enum logic [2:0] {
    ST_DETACHED,
    ST_DEBOUNCE,
    ST_RUN,
    ST_SUSPEND,
    ST_WAKE_OSC,
    ST_WAKE_DRIVE,
    ST_RESUME_END,
    ST_HOST_RESUME
  } ura_state_e;

endpackage

// ==== design/ura_seq.sv ====
/*
  Controller side of a UTMI transceiver: attach, debounce, bus reset, suspend,
  remote wake-up and host resume sequencing, driving the transceiver controls.
  Assumes linestate and vbus_valid arrive asynchronously from pins, and that a
  separate chirp engine reports a granted high-speed mode on hs_mode_set.
*/
`timescale 1ns/1ps
`include "ura_cfg.svh"

module ura_seq #(
  parameter int CNT_W          = 21,
  parameter int WAKE_IDLE_CYC  = `URA_CYC_UP(`URA_T_WAKE_IDLE_MS * `URA_NS_PER_MS),
  parameter int WAKE_DRIVE_CYC = `URA_CYC_DN(`URA_T_WAKE_DRIVE_MS * `URA_NS_PER_MS),
  parameter int OSC_WAIT_CYC   = `URA_CYC_UP(`URA_T_OSC_WAIT_MS * `URA_NS_PER_MS),
  parameter int RESUME_K_CYC   = `URA_CYC_UP(`URA_T_RESUME_K_MS * `URA_NS_PER_MS),
  parameter int RESUME_MIN_CYC = `URA_CYC_UP(`URA_T_RESUME_K_MIN_MS * `URA_NS_PER_MS),
  parameter int RESUME_MAX_CYC = `URA_CYC_DN(`URA_T_RESUME_K_MAX_MS * `URA_NS_PER_MS),
  parameter int SUSP_IDLE_CYC  = `URA_CYC_UP(`URA_T_SUSP_IDLE_MS * `URA_NS_PER_MS),
  parameter int DEBOUNCE_CYC   = `URA_CYC_UP(`URA_T_DEBOUNCE_MS * `URA_NS_PER_MS)
) (
  input  wire logic                   clk,
  input  wire logic                   reset,
  input  wire logic                   vbus_valid,
  input  wire logic [1:0]             linestate,
  input  wire logic                   wake_req,
  input  wire logic                   remote_wake_en,
  input  wire logic                   hs_mode_set,
  output ura_pkg::ura_utmi_ctrl_s     utmi,
  output ura_pkg::ura_status_s        status,
  output logic                        bus_reset
);

  localparam logic [CNT_W-1:0] ONE         = CNT_W'(1);
  localparam logic [CNT_W-1:0] OSC_M1      = CNT_W'(OSC_WAIT_CYC - 1);
  localparam logic [CNT_W-1:0] RESUME_M1   = CNT_W'(RESUME_K_CYC - 1);
  localparam logic [CNT_W-1:0] DEBOUNCE_M1 = CNT_W'(DEBOUNCE_CYC - 1);
  localparam logic [CNT_W-1:0] SUSP_IDLE   = CNT_W'(SUSP_IDLE_CYC);
  localparam logic [CNT_W-1:0] WAKE_IDLE   = CNT_W'(WAKE_IDLE_CYC);
  localparam logic [CNT_W-1:0] WAKE_DRIVE  = CNT_W'(WAKE_DRIVE_CYC);
  localparam logic [CNT_W-1:0] RES_MIN     = CNT_W'(RESUME_MIN_CYC);
  localparam logic [CNT_W-1:0] RES_MAX     = CNT_W'(RESUME_MAX_CYC);
  localparam int               RESTORE_CYC = `URA_RESTORE_CYC;

  // build a control word; fs selects the FS transceiver, term the FS termination
  function automatic ura_pkg::ura_utmi_ctrl_s ctrl_word(input logic susp_n,
                                                         input logic fs,
                                                         input logic term,
                                                         input logic drive_k);
    ura_pkg::ura_utmi_ctrl_s c;
    c.suspendn   = susp_n;
    c.opmode     = drive_k ? `URA_OPM_NO_STUFF : `URA_OPM_NORMAL;
    c.termselect = term;
    c.xcvrselect = fs;
    c.txvalid    = drive_k;
    c.txdata     = `URA_TXDATA_ZERO;
    return c;
  endfunction

  // --------------------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------------------
  logic [1:0] ls_meta_reg;
  logic [1:0] ls_sync_reg;
  logic       vb_meta_reg;
  logic       vb_sync_reg;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ls_meta_reg <= `URA_LS_SE0;
      ls_sync_reg <= `URA_LS_SE0;
      vb_meta_reg <= 1'b0;
      vb_sync_reg <= 1'b0;
    end else begin
      ls_meta_reg <= linestate;
      ls_sync_reg <= ls_meta_reg;
      vb_meta_reg <= vbus_valid;
      vb_sync_reg <= vb_meta_reg;
    end
  end

  // --------------------------------------------------------------------------
  // line qualification
  // --------------------------------------------------------------------------
  logic [1:0] filt_state;
  logic       filt_valid;

  ura_line_filter #(
    .FILT_CYC   (`URA_FILT_CYC)
  ) u_filter (
    .clk        (clk),
    .reset      (reset),
    .line_in    (ls_sync_reg),
    .line_state (filt_state),
    .line_valid (filt_valid)
  );

  logic j_valid;
  logic k_valid;
  logic se0_valid;
  logic se0_raw;

  assign j_valid   = filt_valid && (filt_state == `URA_LS_J);
  assign k_valid   = filt_valid && (filt_state == `URA_LS_K);
  assign se0_valid = filt_valid && (filt_state == `URA_LS_SE0);
  // the closing EOP is shorter than the filter, so it is taken unfiltered
  assign se0_raw   = (ls_sync_reg == `URA_LS_SE0);

  // --------------------------------------------------------------------------
  // state machine
  // --------------------------------------------------------------------------
  ura_pkg::ura_state_e state_reg;
  ura_pkg::ura_state_e state_next;
  logic [CNT_W-1:0]    cnt_reg;
  logic [CNT_W-1:0]    idle_reg;
  logic                wake_pend_reg;
  logic                mode_hs_reg;
  logic                reset_evt;

  always_comb begin
    state_next = state_reg;
    reset_evt  = 1'b0;
    case (state_reg)
      ura_pkg::ST_DETACHED: begin
        if (vb_sync_reg) begin
          state_next = ura_pkg::ST_DEBOUNCE;
        end
      end
      ura_pkg::ST_DEBOUNCE: begin
        if (!vb_sync_reg) begin
          state_next = ura_pkg::ST_DETACHED;
        end else if (cnt_reg == DEBOUNCE_M1) begin
          state_next = ura_pkg::ST_RUN;
        end
      end
      ura_pkg::ST_RUN: begin
        if (!vb_sync_reg) begin
          state_next = ura_pkg::ST_DETACHED;
        end else if (se0_valid) begin
          reset_evt = 1'b1;
        end else if (idle_reg >= SUSP_IDLE) begin
          state_next = ura_pkg::ST_SUSPEND;
        end
      end
      ura_pkg::ST_SUSPEND: begin
        if (!vb_sync_reg) begin
          state_next = ura_pkg::ST_DETACHED;
        end else if (k_valid) begin
          state_next = ura_pkg::ST_HOST_RESUME;
        end else if (se0_valid) begin
          reset_evt  = 1'b1;
          state_next = ura_pkg::ST_RUN;
        end else if (wake_pend_reg && remote_wake_en && idle_reg >= WAKE_IDLE) begin
          state_next = ura_pkg::ST_WAKE_OSC;
        end
      end
      ura_pkg::ST_WAKE_OSC: begin
        // transceiver clock settles while the wake window runs
        if (cnt_reg == OSC_M1) begin
          state_next = ura_pkg::ST_WAKE_DRIVE;
        end
      end
      ura_pkg::ST_WAKE_DRIVE: begin
        if (cnt_reg == RESUME_M1) begin
          state_next = ura_pkg::ST_RESUME_END;
        end
      end
      ura_pkg::ST_RESUME_END: begin
        // downstream port holds K until it drives the closing SE0
        if (se0_raw) begin
          state_next = ura_pkg::ST_RUN;
        end
      end
      ura_pkg::ST_HOST_RESUME: begin
        if (se0_raw) begin
          state_next = ura_pkg::ST_RUN;
        end
      end
      default: begin
        state_next = ura_pkg::ST_DETACHED;
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= ura_pkg::ST_DETACHED;
    end else begin
      state_reg <= state_next;
    end
  end

  // one shared interval timer, cleared on every state change
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_reg <= '0;
    end else if (state_next != state_reg) begin
      cnt_reg <= '0;
    end else if (cnt_reg != {CNT_W{1'b1}}) begin
      cnt_reg <= cnt_reg + ONE;
    end
  end

  // bus idle time, saturating
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      idle_reg <= '0;
    end else if (!j_valid) begin
      idle_reg <= '0;
    end else if (idle_reg != {CNT_W{1'b1}}) begin
      idle_reg <= idle_reg + ONE;
    end
  end

  // a wake request is only meaningful while suspended; set wins over clear
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wake_pend_reg <= 1'b0;
    end else if (wake_req && state_reg == ura_pkg::ST_SUSPEND) begin
      wake_pend_reg <= 1'b1;
    end else if (state_reg != ura_pkg::ST_SUSPEND) begin
      wake_pend_reg <= 1'b0;
    end
  end

  // speed before suspend; bus reset or detach drops back to FS
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mode_hs_reg <= 1'b0;
    end else if (reset_evt || state_reg == ura_pkg::ST_DETACHED) begin
      mode_hs_reg <= 1'b0;
    end else if (hs_mode_set && state_reg == ura_pkg::ST_RUN) begin
      mode_hs_reg <= 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // registered outputs
  // --------------------------------------------------------------------------
  ura_pkg::ura_utmi_ctrl_s utmi_next;
  ura_pkg::ura_utmi_ctrl_s utmi_reg;
  logic                    bus_reset_reg;

  always_comb begin
    case (state_next)
      // pull-up off until VBUS is seen
      ura_pkg::ST_DETACHED:    utmi_next = ctrl_word(1'b1, 1'b1, 1'b0, 1'b0);
      ura_pkg::ST_DEBOUNCE:    utmi_next = ctrl_word(1'b1, 1'b1, 1'b1, 1'b0);
      ura_pkg::ST_RUN:         utmi_next = ctrl_word(1'b1, !mode_hs_reg, !mode_hs_reg, 1'b0);
      ura_pkg::ST_SUSPEND:     utmi_next = ctrl_word(1'b0, 1'b1, 1'b1, 1'b0);
      ura_pkg::ST_WAKE_OSC:    utmi_next = ctrl_word(1'b1, 1'b1, 1'b1, 1'b0);
      ura_pkg::ST_WAKE_DRIVE:  utmi_next = ctrl_word(1'b1, 1'b1, 1'b1, 1'b1);
      ura_pkg::ST_RESUME_END:  utmi_next = ctrl_word(1'b1, 1'b1, 1'b1, 1'b0);
      ura_pkg::ST_HOST_RESUME: utmi_next = ctrl_word(1'b1, 1'b1, 1'b1, 1'b0);
      default:                 utmi_next = ctrl_word(1'b1, 1'b1, 1'b0, 1'b0);
    endcase
    // a bus reset forces FS at once, even out of HS
    if (reset_evt) begin
      utmi_next = ctrl_word(1'b1, 1'b1, 1'b1, 1'b0);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      utmi_reg <= '{1'b1, `URA_OPM_NORMAL, 1'b0, 1'b1, 1'b0, `URA_TXDATA_ZERO};
    end else begin
      utmi_reg <= utmi_next;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bus_reset_reg <= 1'b0;
    end else begin
      bus_reset_reg <= reset_evt;
    end
  end

  assign utmi             = utmi_reg;
  assign bus_reset        = bus_reset_reg;
  assign status.attached  = utmi_reg.termselect || mode_hs_reg;
  assign status.suspended = (state_reg == ura_pkg::ST_SUSPEND);
  assign status.hs_mode   = mode_hs_reg;
  assign status.resuming  = (state_reg == ura_pkg::ST_WAKE_OSC) || (state_reg == ura_pkg::ST_WAKE_DRIVE) ||
                            (state_reg == ura_pkg::ST_RESUME_END) || (state_reg == ura_pkg::ST_HOST_RESUME);

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  logic [CNT_W-1:0] k_len_reg;
  logic [CNT_W-1:0] idle_at_wake_reg;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      k_len_reg        <= '0;
      idle_at_wake_reg <= '0;
    end else if (state_reg == ura_pkg::ST_SUSPEND && state_next == ura_pkg::ST_WAKE_OSC) begin
      k_len_reg        <= '0;
      idle_at_wake_reg <= idle_reg;
    end else if (utmi_reg.txvalid) begin
      k_len_reg <= k_len_reg + ONE;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_resume_ends;
    (state_reg == ura_pkg::ST_RESUME_END || state_reg == ura_pkg::ST_HOST_RESUME) && se0_raw;
  endsequence

  a_resume_k_fields: assert property (utmi_reg.txvalid |-> utmi_reg.opmode == `URA_OPM_NO_STUFF &&
                                      utmi_reg.termselect && utmi_reg.xcvrselect &&
                                      utmi_reg.txdata == `URA_TXDATA_ZERO)
    else $error("resume K driven with wrong controls");

  a_resume_k_len: assert property ($fell(utmi_reg.txvalid) |-> k_len_reg >= RES_MIN && k_len_reg <= RES_MAX)
    else $error("resume K length out of range");

  a_wake_idle_gap: assert property ($rose(utmi_reg.txvalid) |-> idle_at_wake_reg >= WAKE_IDLE)
    else $error("remote wake started before bus idle time");

  a_wake_drive_bound: assert property (state_reg == ura_pkg::ST_WAKE_OSC |-> cnt_reg < WAKE_DRIVE)
    else $error("resume not driven within wake window");

  a_hs_restore: assert property (s_resume_ends ##0 mode_hs_reg |-> ##[1:RESTORE_CYC]
                                 (!utmi_reg.termselect && !utmi_reg.xcvrselect && utmi_reg.suspendn))
    else $error("HS mode not restored after resume");

  a_fs_keep: assert property (s_resume_ends ##0 !mode_hs_reg |=>
                              (utmi_reg.termselect && utmi_reg.xcvrselect)[*3])
    else $error("FS selects dropped after resume");

  a_host_wake: assert property (state_reg == ura_pkg::ST_SUSPEND && k_valid && vb_sync_reg |=>
                                utmi_reg.suspendn && state_reg == ura_pkg::ST_HOST_RESUME)
    else $error("suspend not left on J to K");

  a_attach_fs: assert property (state_reg == ura_pkg::ST_DETACHED && vb_sync_reg |=>
                                utmi_reg.termselect && utmi_reg.xcvrselect)
    else $error("attach did not select FS");

  a_bus_reset_src: assert property (bus_reset_reg |-> $past(se0_valid) && !mode_hs_reg &&
                                    $past(state_reg) != ura_pkg::ST_DEBOUNCE)
    else $error("bus reset without qualified SE0 after debounce");

  a_suspend_only: assert property (!utmi_reg.suspendn |-> state_reg == ura_pkg::ST_SUSPEND)
    else $error("suspend asserted outside suspend state");

endmodule

// ==== sim/testbench.sv ====
/*
  Self-checking bench for the sequencer: attach, bus reset, host resume, remote wake.
  Assumes shortened interval parameters; all counts stay in controller clock cycles.
*/
`timescale 1ns/1ps
`include "ura_cfg.svh"

module testbench;
  logic                    clk            = 1'b0;
  logic                    reset          = 1'b1;
  logic                    vbus_valid     = 1'b0;
  logic                    wake_req       = 1'b0;
  logic                    remote_wake_en = 1'b0;
  logic                    hs_mode_set    = 1'b0;
  logic                    host_drive     = 1'b0;
  logic [1:0]              host_ls        = `URA_LS_J;
  logic [1:0]              linestate;
  logic                    dp_pullup;
  logic                    bus_reset;
  ura_pkg::ura_utmi_ctrl_s utmi;
  ura_pkg::ura_status_s    status;
  int                      n_mismatch     = 0;
  int                      comparisons    = 0;
  int                      i;
  int                      n;

  localparam int OSC_CYC    = 10;
  localparam int CYC_PER_MS = `URA_NS_PER_MS / `URA_CLK_PERIOD_NS;
  localparam int DRIVE_CYC  = `URA_T_WAKE_DRIVE_MS * CYC_PER_MS;
  localparam int K_MIN_CYC  = `URA_T_RESUME_K_MIN_MS * CYC_PER_MS;
  localparam int K_MAX_CYC  = `URA_T_RESUME_K_MAX_MS * CYC_PER_MS;

  always #50 clk = ~clk;

  // short idle and debounce times keep the run brief; resume K keeps its full length
  ura_seq #(.WAKE_IDLE_CYC(40), .OSC_WAIT_CYC(OSC_CYC), .SUSP_IDLE_CYC(60), .DEBOUNCE_CYC(50)) dut_u (
    .clk            (clk),
    .reset          (reset),
    .vbus_valid     (vbus_valid),
    .linestate      (linestate),
    .wake_req       (wake_req),
    .remote_wake_en (remote_wake_en),
    .hs_mode_set    (hs_mode_set),
    .utmi           (utmi),
    .status         (status),
    .bus_reset      (bus_reset)
  );

  ura_xcvr_model model_u (
    .utmi       (utmi),
    .host_drive (host_drive),
    .host_ls    (host_ls),
    .linestate  (linestate),
    .dp_pullup  (dp_pullup)
  );

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int cnt);
    repeat (cnt) @(negedge clk);
  endtask

  task automatic print_verdict();
    $display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic wait_suspend();
    for (i = 0; i < 120 && status.suspended !== 1'b1; i++) tick(1);
    chk(16'(status.suspended), 16'h0001);
    chk(16'(utmi.suspendn), 16'h0000);
  endtask

  // --------------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------------
  task automatic t_reset();
    chk(16'(utmi), 16'h2200);
    chk(16'(dp_pullup), 16'h0000);
  endtask

  task automatic t_attach();
    vbus_valid = 1'b1;
    for (i = 0; i < 10 && utmi.termselect !== 1'b1; i++) tick(1);
    chk({14'h0000, utmi.termselect, utmi.xcvrselect}, 16'h0003);
    chk(16'(dp_pullup), 16'h0001);
    for (i = 0; i < 70 && status.attached !== 1'b1; i++) tick(1);
    chk(16'(status.attached), 16'h0001);
    host_drive = 1'b1;
    host_ls = `URA_LS_SE0;
    for (i = 0; i < 80 && bus_reset !== 1'b1; i++) tick(1);
    chk(16'(bus_reset), 16'h0001);
    chk(16'(status.hs_mode), 16'h0000);
    host_ls = `URA_LS_J;
    tick(5);
  endtask

  task automatic t_fs_resume();
    wait_suspend();
    wake_req = 1'b1;
    tick(1);
    wake_req = 1'b0;
    tick(60);
    chk(16'(utmi.txvalid), 16'h0000);
    host_ls = `URA_LS_K;
    tick(20);
    chk(16'(utmi.suspendn), 16'h0000);
    for (i = 0; i < 20 && utmi.suspendn !== 1'b1; i++) tick(1);
    chk(16'(utmi.suspendn), 16'h0001);
    tick(10);
    host_ls = `URA_LS_SE0;
    tick(12);
    chk({14'h0000, utmi.termselect, utmi.xcvrselect}, 16'h0003);
    chk(16'(status.suspended), 16'h0000);
    tick(2);
    host_ls = `URA_LS_J;
    tick(3);
  endtask

  task automatic t_hs_wake();
    hs_mode_set = 1'b1;
    tick(1);
    hs_mode_set = 1'b0;
    tick(2);
    chk(16'(status.hs_mode), 16'h0001);
    wait_suspend();
    remote_wake_en = 1'b1;
    wake_req = 1'b1;
    tick(1);
    wake_req = 1'b0;
    for (i = 0; i < 200 && utmi.txvalid !== 1'b1; i++) tick(1);
    chk(16'(i < DRIVE_CYC), 16'h0001);
    chk(16'(i >= OSC_CYC), 16'h0001);
    chk({3'h0, utmi.opmode, utmi.termselect, utmi.xcvrselect, utmi.txvalid, utmi.txdata}, 16'h1700);
    chk(16'(utmi.suspendn), 16'h0001);
    chk(16'(status.resuming), 16'h0001);
    host_ls = `URA_LS_K;
    for (n = 0; n < 200000 && utmi.txvalid === 1'b1; n++) tick(1);
    chk(16'(n >= K_MIN_CYC && n <= K_MAX_CYC), 16'h0001);
    tick(10);
    host_ls = `URA_LS_SE0;
    tick(12);
    chk({14'h0000, utmi.termselect, utmi.xcvrselect}, 16'h0000);
    chk(16'(status.hs_mode), 16'h0001);
    chk(16'(status.resuming), 16'h0000);
    tick(2);
    host_ls = `URA_LS_J;
    tick(3);
  endtask

  // --------------------------------------------------------------------------
  // sequence and watchdog
  // --------------------------------------------------------------------------
  initial begin
    tick(3);
    reset = 1'b0;
    t_reset();
    t_attach();
    t_fs_resume();
    t_hs_wake();
    print_verdict();
  end

  initial begin
    #4000000;
    n_mismatch++;
    print_verdict();
  end
endmodule

// ==== sim/ura_xcvr_model.sv ====
/*
  Behavioural transceiver standing between the sequencer and the bus.
  Assumes the bench plays the downstream port through host_drive and host_ls.
*/
`timescale 1ns/1ps
`include "ura_cfg.svh"

module ura_xcvr_model (
  input  wire ura_pkg::ura_utmi_ctrl_s utmi,
  input  wire logic                    host_drive,
  input  wire logic [1:0]              host_ls,
  output logic      [1:0]              linestate,
  output logic                         dp_pullup
);
  // --------------------------------------------------------------------------
  // line
  // --------------------------------------------------------------------------
  assign dp_pullup = utmi.termselect;

  // undriven bus idles at J through the pull-up, and falls to SE0 through the port pull-downs when the pull-up is off
  always_comb begin
    if (utmi.txvalid && utmi.opmode == `URA_OPM_NO_STUFF) begin
      linestate = `URA_LS_K;
    end else if (host_drive) begin
      linestate = host_ls;
    end else if (dp_pullup) begin
      linestate = `URA_LS_J;
    end else begin
      linestate = `URA_LS_SE0;
    end
  end
endmodule
